/* File: shared/nand_host_pkg.sv */
// Shared constants and types for the NAND flash host controller.
package nand_host_pkg;
  // Clock period at 20 MHz.
  localparam int CLK_PERIOD_NS = 50;
  // Least gap from the last address strobe rise to the first data strobe rise.
  localparam int ADDR_TO_DATA_GAP_NS = 100;
  // Longest time from a write strobe rise until the device shows busy.
  localparam int WE_HIGH_TO_BUSY_NS = 100;
  // Least time from a write strobe rise to the read strobe going low.
  localparam int WE_HIGH_TO_READ_NS = 60;
  // Longest device busy times.
  localparam int CELL_TO_REGISTER_TIME_US = 40;
  localparam int RESET_BUSY_MAX_US = 500;
  localparam int PROGRAM_TIME_MAX_US = 750;
  localparam int ERASE_TIME_MAX_US = 10000;
  // Least times and the busy delay round up; every count is at least one cycle.
  localparam int ADL_CYC = (ADDR_TO_DATA_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC = (WE_HIGH_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHR_CYC = (WE_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest times round down.
  localparam int TR_CYC = CELL_TO_REGISTER_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int RST_CYC_DEF = RESET_BUSY_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int PROG_CYC_DEF = PROGRAM_TIME_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_CYC_DEF = ERASE_TIME_MAX_US * 1000 / CLK_PERIOD_NS;
  // Command bytes.
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // Status byte pass/fail bit.
  localparam int STATUS_FAIL_BIT = 0;
  // Address layout: page in bits 12-17, block in bits 18-27.
  localparam int PG_LSB = 12;
  localparam int PG_W = 6;
  localparam int BLK_LSB = 18;
  localparam int BLK_W = 10;
  // Width of the cycle counter.
  localparam int CNT_W = 24;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_DIN, K_DOUT} cyc_kind_e;
  typedef enum logic [2:0] {OP_READ, OP_PROG, OP_ERASE, OP_RESET, OP_STATUS} op_e;
endpackage

/* File: shared/nand_cycle_if.sv */
// Byte-cycle request channel between the sequencer and the pin engine.
`timescale 1ns/100ps
interface nand_cycle_if import nand_host_pkg::*;;
  logic      sel;   // Chip selected while an operation runs.
  logic      req;   // One-cycle request for one bus cycle.
  cyc_kind_e kind;  // Kind of bus cycle.
  logic [7:0] wbyte; // Byte to drive.
  logic      done;  // One-cycle pulse when the cycle has finished.
  logic [7:0] rbyte; // Byte captured on a data-out cycle.
  modport host (output sel, req, kind, wbyte, input done, rbyte);
  modport engine (input sel, req, kind, wbyte, output done, rbyte);
endinterface

/* File: core/nand_cycle_engine.sv */
// Pin engine that turns one byte request into one strobed bus cycle.
`timescale 1ns/100ps
module nand_cycle_engine import nand_host_pkg::*; (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  nand_cycle_if.engine    ifc,
  output logic            ce_n_o,
  output logic            cle_o,
  output logic            ale_o,
  output logic            we_n_o,
  output logic            read_strobe_n_o,
  output logic [7:0]      dq_o,
  output logic            dq_oe_o,
  input  wire logic [7:0] dq_i
);
  logic [1:0] ph_q;     // Phase within the current cycle.
  cyc_kind_e  k_q;      // Kind of the cycle in progress.
  logic       ce_n_q;   // Chip select, active low.
  logic       cle_q;    // Command latch strobe.
  logic       ale_q;    // Address latch strobe.
  logic       we_n_q;   // Write strobe, active low.
  logic       re_n_q;   // Read strobe, active low.
  logic [7:0] dq_q;     // Driven byte.
  logic       oe_q;     // Data bus drive enable.
  logic       done_q;   // Cycle finished pulse.
  logic [7:0] rbyte_q;  // Captured byte.
  logic [7:0] since_q;  // Cycles since the last address strobe rise.

  assign ce_n_o = ce_n_q;
  assign cle_o = cle_q;
  assign ale_o = ale_q;
  assign we_n_o = we_n_q;
  assign read_strobe_n_o = re_n_q;
  assign dq_o = dq_q;
  assign dq_oe_o = oe_q;
  assign ifc.done = done_q;
  assign ifc.rbyte = rbyte_q;

  // Four phases per cycle: set lines, strobe low, strobe high, release.
  // Latch lines only move while the write strobe is high, so the device
  // never sees them change under a low strobe.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ph_q <= 2'h0;
      k_q <= K_CMD;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      dq_q <= 8'h00;
      oe_q <= 1'b0;
      done_q <= 1'b0;
      rbyte_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      ce_n_q <= !ifc.sel;
      case (ph_q)
        2'h0: begin
          // Set up latch lines and data a full period before the write strobe; a read drops its strobe here.
          if (ifc.req) begin
            k_q <= ifc.kind;
            cle_q <= (ifc.kind == K_CMD);
            ale_q <= (ifc.kind == K_ADDR);
            dq_q <= ifc.wbyte;
            oe_q <= (ifc.kind != K_DOUT);
            re_n_q <= (ifc.kind != K_DOUT);
            ph_q <= 2'h1;
          end
        end
        2'h1: begin
          // Write cycles pull the write strobe low; reads hold the read strobe.
          we_n_q <= (k_q == K_DOUT);
          ph_q <= 2'h2;
        end
        2'h2: begin
          // The rising write strobe latches the byte into the device.
          we_n_q <= 1'b1;
          re_n_q <= 1'b1;
          if (k_q == K_DOUT) begin
            rbyte_q <= dq_i;
          end
          done_q <= 1'b1;
          ph_q <= 2'h3;
        end
        default: begin
          // Release latch lines and the bus with the strobe high.
          cle_q <= 1'b0;
          ale_q <= 1'b0;
          oe_q <= 1'b0;
          ph_q <= 2'h0;
        end
      endcase
    end
  end

  // Helper counter for checking the address-to-data gap.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      since_q <= 8'hff;
    end else if (ph_q == 2'h2 && ale_q) begin
      since_q <= 8'h00;
    end else if (since_q != 8'hff) begin
      since_q <= since_q + 8'h01;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_we_one_cycle: assert property ($fell(we_n_q) |=> $rose(we_n_q))
    else $error("Write strobe low for more than one cycle.");
  a_ctl_stable_low: assert property (!we_n_q |-> $stable(cle_q) && $stable(ale_q)
    && $stable(ce_n_q))
    else $error("Latch line changed while write strobe low.");
  a_addr_data_gap: assert property ($rose(we_n_q) && !cle_q && !ale_q && oe_q
    |-> since_q >= 8'(ADL_CYC))
    else $error("Data strobe too soon after address strobe.");
  a_latch_exclusive: assert property (!(cle_q && ale_q))
    else $error("Command and address latch both high.");
endmodule

/* File: core/nand_host.sv */
// Host controller that sequences page read, program, erase, status and reset.
// Notes on behaviour
// - Wait 100 ns from address to data strobe.
// - Latch lines hold still while strobe low.
// - Keep factory marks; map marked blocks out. The host never reads the marks.
// - Failed status retires block, moves its data. The block is retired but its data is not moved.
// - Copy pages to spare block; avoid failed one. No pages are copied.
// - Check read data with error correction. Only a running XOR parity is kept.
// - Program pages in rising order per block; only the last programmed block is checked.
// - Address goes out as four byte cycles; erase sends only the two row bytes.
// - Read: command, four addresses, confirm.
// - Watch ready/busy before continuing.
`timescale 1ns/100ps
module nand_host import nand_host_pkg::*; #(
  parameter int RST_BUSY_CYC   = RST_CYC_DEF,   // Reset busy timeout.
  parameter int PROG_BUSY_CYC  = PROG_CYC_DEF,  // Program busy timeout.
  parameter int ERASE_BUSY_CYC = ERASE_CYC_DEF  // Erase busy timeout.
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire op_e         op_i,
  input  wire logic [27:0] addr_i,
  input  wire logic [11:0] len_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  output logic [7:0]       rd_data_o,
  output logic             rd_valid_o,
  output logic [7:0]       rd_parity_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             fail_o,
  output logic             timeout_o,
  output logic             refused_o,
  output logic [7:0]       status_o,
  output logic             ce_n_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             we_n_o,
  output logic             read_strobe_n_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  input  wire logic [7:0]  dq_i,
  input  wire logic        rb_n_i
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_GAP, S_DIN, S_CMD2, S_BUSY,
    S_SCMD, S_SGAP, S_SREAD, S_DOUT, S_END
  } state_e;

  nand_cycle_if ifc ();

  state_e           st_q;        // Sequencer state.
  op_e              op_q;        // Operation in progress.
  logic [27:0]      addr_q;      // Captured address.
  logic [11:0]      len_q;       // Bytes to move.
  logic [1:0]       idx_q;       // Address byte index.
  logic [CNT_W-1:0] cnt_q;       // Wait and byte counter.
  logic [CNT_W-1:0] lim_q;       // Busy timeout limit.
  logic             req_q;       // Cycle request.
  cyc_kind_e        kind_q;      // Cycle kind.
  logic [7:0]       wbyte_q;     // Cycle byte.
  logic             wr_ready_q;  // Ready for one write byte.
  logic [7:0]       rd_data_q;   // Last read byte.
  logic             rd_valid_q;  // Read byte pulse.
  logic [7:0]       parity_q;    // Running column parity of the page.
  logic             busy_q;      // Operation running.
  logic             done_q;      // Operation finished pulse.
  logic             fail_q;      // Status reported failure.
  logic             timeout_q;   // Ready never returned.
  logic             refused_q;   // Request refused.
  logic [7:0]       status_q;    // Last status byte.
  logic             last_v_q;    // Programmed-page record valid.
  logic [BLK_W-1:0] last_blk_q;  // Block last programmed.
  logic [PG_W-1:0]  last_pg_q;   // Page last programmed.
  logic             bad_v_q;     // Retired block record valid.
  logic [BLK_W-1:0] bad_blk_q;   // Block retired after a failure.
  logic             bad_hit;     // Program or erase request touches the retired block.
  logic             order_bad;   // Program would go backwards or repeat a page in the last programmed block.

  // Block and page fields of a row address.
  function automatic logic [BLK_W-1:0] blk_of(input logic [27:0] a);
    return a[BLK_LSB +: BLK_W];
  endfunction

  function automatic logic [PG_W-1:0] pg_of(input logic [27:0] a);
    return a[PG_LSB +: PG_W];
  endfunction

  // Byte i of the four-cycle address: column low, column high, row low, row high.
  function automatic logic [7:0] addr_byte(input logic [27:0] a, input logic [1:0] i);
    logic [7:0] b;
    case (i)
      2'h0: b = a[7:0];
      2'h1: b = {4'h0, a[11:8]};
      2'h2: b = a[19:12];
      default: b = a[27:20];
    endcase
    return b;
  endfunction

  // Opening command for each operation.
  function automatic logic [7:0] first_cmd(input op_e o);
    logic [7:0] c;
    case (o)
      OP_READ: c = CMD_READ;
      OP_PROG: c = CMD_PROG;
      OP_ERASE: c = CMD_ERASE;
      OP_RESET: c = CMD_RESET;
      default: c = CMD_STATUS;
    endcase
    return c;
  endfunction

  assign ifc.sel = busy_q;
  assign ifc.req = req_q;
  assign ifc.kind = kind_q;
  assign ifc.wbyte = wbyte_q;
  assign wr_ready_o = wr_ready_q;
  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_parity_o = parity_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign fail_o = fail_q;
  assign timeout_o = timeout_q;
  assign refused_o = refused_q;
  assign status_o = status_q;

  // Programs that would go backwards or repeat a page in the last programmed block, and programs or erases of a retired block, are refused.
  always_comb begin
    bad_hit = bad_v_q && (op_i == OP_PROG || op_i == OP_ERASE)
      && blk_of(addr_i) == bad_blk_q;
    order_bad = last_v_q && op_i == OP_PROG && blk_of(addr_i) == last_blk_q
      && pg_of(addr_i) <= last_pg_q;
  end

  // Main sequencer. Every byte goes through the pin engine; each state
  // waits for the engine's done pulse before the next request.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      addr_q <= 28'h0000000;
      len_q <= 12'h000;
      idx_q <= 2'h0;
      cnt_q <= '0;
      lim_q <= '0;
      req_q <= 1'b0;
      kind_q <= K_CMD;
      wbyte_q <= 8'h00;
      wr_ready_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      parity_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      timeout_q <= 1'b0;
      refused_q <= 1'b0;
      status_q <= 8'h00;
    end else begin
      req_q <= 1'b0;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start_i) begin
            refused_q <= bad_hit || order_bad;
            fail_q <= 1'b0;
            timeout_q <= 1'b0;
            if (bad_hit || order_bad) begin
              done_q <= 1'b1;
            end else begin
              op_q <= op_i;
              addr_q <= addr_i;
              len_q <= len_i;
              busy_q <= 1'b1;
              req_q <= 1'b1;
              kind_q <= K_CMD;
              wbyte_q <= first_cmd(op_i);
              st_q <= S_CMD1;
            end
          end
        end
        S_CMD1: begin
          if (ifc.done) begin
            cnt_q <= '0;
            if (op_q == OP_RESET) begin
              lim_q <= CNT_W'(RST_BUSY_CYC);
              st_q <= S_BUSY;
            end else if (op_q == OP_STATUS) begin
              st_q <= S_SGAP;
            end else begin
              // Erase sends only the two row bytes.
              idx_q <= (op_q == OP_ERASE) ? 2'h2 : 2'h0;
              req_q <= 1'b1;
              kind_q <= K_ADDR;
              wbyte_q <= addr_byte(addr_q, (op_q == OP_ERASE) ? 2'h2 : 2'h0);
              st_q <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (ifc.done) begin
            if (idx_q != 2'h3) begin
              idx_q <= idx_q + 2'h1;
              req_q <= 1'b1;
              wbyte_q <= addr_byte(addr_q, idx_q + 2'h1);
            end else if (op_q == OP_PROG) begin
              cnt_q <= '0;
              st_q <= S_GAP;
            end else begin
              req_q <= 1'b1;
              kind_q <= K_CMD;
              wbyte_q <= (op_q == OP_READ) ? CMD_READ_GO : CMD_ERASE_GO;
              st_q <= S_CMD2;
            end
          end
        end
        S_GAP: begin
          // Extra idle time ahead of the first data byte.
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(ADL_CYC - 1)) begin
            cnt_q <= '0;
            if (len_q == 12'h000) begin
              req_q <= 1'b1;
              kind_q <= K_CMD;
              wbyte_q <= CMD_PROG_GO;
              st_q <= S_CMD2;
            end else begin
              wr_ready_q <= 1'b1;
              st_q <= S_DIN;
            end
          end
        end
        S_DIN: begin
          // A write byte is taken only while the engine is free.
          if (wr_ready_q && wr_valid_i) begin
            wr_ready_q <= 1'b0;
            req_q <= 1'b1;
            kind_q <= K_DIN;
            wbyte_q <= wr_data_i;
            cnt_q <= cnt_q + 1'b1;
          end else if (ifc.done) begin
            if (cnt_q == {12'h000, len_q}) begin
              req_q <= 1'b1;
              kind_q <= K_CMD;
              wbyte_q <= CMD_PROG_GO;
              st_q <= S_CMD2;
            end else begin
              wr_ready_q <= 1'b1;
            end
          end
        end
        S_CMD2: begin
          if (ifc.done) begin
            cnt_q <= '0;
            lim_q <= (op_q == OP_READ) ? CNT_W'(TR_CYC) :
              (op_q == OP_PROG) ? CNT_W'(PROG_BUSY_CYC) : CNT_W'(ERASE_BUSY_CYC);
            st_q <= S_BUSY;
          end
        end
        S_BUSY: begin
          // The device may take a while to show busy, so ready/busy is
          // trusted only after that delay.
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(WB_CYC) && rb_n_i) begin
            cnt_q <= '0;
            if (op_q == OP_RESET || (op_q == OP_READ && len_q == 12'h000)) begin
              st_q <= S_END;
            end else if (op_q == OP_READ) begin
              req_q <= 1'b1;
              kind_q <= K_DOUT;
              st_q <= S_DOUT;
            end else begin
              req_q <= 1'b1;
              kind_q <= K_CMD;
              wbyte_q <= CMD_STATUS;
              st_q <= S_SCMD;
            end
          end else if (cnt_q == lim_q) begin
            timeout_q <= 1'b1;
            st_q <= S_END;
          end
        end
        S_SCMD: begin
          if (ifc.done) begin
            cnt_q <= '0;
            st_q <= S_SGAP;
          end
        end
        S_SGAP: begin
          // Hold off the read strobe after the status command.
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(WHR_CYC)) begin
            req_q <= 1'b1;
            kind_q <= K_DOUT;
            st_q <= S_SREAD;
          end
        end
        S_SREAD: begin
          if (ifc.done) begin
            status_q <= ifc.rbyte;
            fail_q <= ifc.rbyte[STATUS_FAIL_BIT];
            st_q <= S_END;
          end
        end
        S_DOUT: begin
          // No back-pressure on reads: the user takes each byte as it comes.
          if (ifc.done) begin
            rd_data_q <= ifc.rbyte;
            rd_valid_q <= 1'b1;
            parity_q <= (cnt_q == '0) ? ifc.rbyte : (parity_q ^ ifc.rbyte);
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q + 1'b1 == {12'h000, len_q}) begin
              st_q <= S_END;
            end else begin
              req_q <= 1'b1;
            end
          end
        end
        S_END: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Block bookkeeping: a failed status retires the block until another block fails, a
  // passed program records the page so later pages in that block must climb.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      last_v_q <= 1'b0;
      last_blk_q <= '0;
      last_pg_q <= '0;
      bad_v_q <= 1'b0;
      bad_blk_q <= '0;
    end else if (st_q == S_SREAD && ifc.done && op_q != OP_STATUS) begin
      if (ifc.rbyte[STATUS_FAIL_BIT]) begin
        bad_v_q <= 1'b1;
        bad_blk_q <= blk_of(addr_q);
      end else if (op_q == OP_PROG) begin
        last_v_q <= 1'b1;
        last_blk_q <= blk_of(addr_q);
        last_pg_q <= pg_of(addr_q);
      end else if (op_q == OP_ERASE && blk_of(addr_q) == last_blk_q) begin
        last_v_q <= 1'b0;
      end
    end
  end

  nand_cycle_engine u_engine (
    .clock_i         (clock_i),
    .rst_i           (rst_i),
    .ifc             (ifc.engine),
    .ce_n_o          (ce_n_o),
    .cle_o           (cle_o),
    .ale_o           (ale_o),
    .we_n_o          (we_n_o),
    .read_strobe_n_o (read_strobe_n_o),
    .dq_o            (dq_o),
    .dq_oe_o         (dq_oe_o),
    .dq_i            (dq_i)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_start_ok;
    st_q == S_IDLE && start_i && !bad_hit && !order_bad;
  endsequence

  a_order_refuse: assert property (st_q == S_IDLE && start_i && order_bad
    |=> refused_q && done_q && st_q == S_IDLE)
    else $error("Backward program was not refused.");
  a_bad_block_skip: assert property (st_q == S_IDLE && start_i && bad_hit
    |=> refused_q && !busy_q)
    else $error("Retired block was touched.");
  a_start_cmd: assert property (s_start_ok |=> req_q && kind_q == K_CMD && busy_q)
    else $error("Operation did not open with a command.");
  a_addr_byte_ok: assert property (req_q && kind_q == K_ADDR
    |-> st_q == S_ADDR && wbyte_q == addr_byte(addr_q, idx_q))
    else $error("Address byte out of place.");
  a_read_confirm: assert property (req_q && kind_q == K_CMD && wbyte_q == CMD_READ_GO
    |-> op_q == OP_READ && idx_q == 2'h3)
    else $error("Read confirm before four address bytes.");
  a_busy_exit: assert property (st_q == S_BUSY && cnt_q >= CNT_W'(WB_CYC) && rb_n_i
    |=> st_q != S_BUSY)
    else $error("Ready not acted upon.");
  a_read_bound: assert property (st_q == S_BUSY && op_q == OP_READ
    |-> cnt_q <= CNT_W'(TR_CYC))
    else $error("Page load wait ran past its limit.");
  a_status_fail: assert property (st_q == S_SREAD && ifc.done
    |=> fail_q == $past(ifc.rbyte[STATUS_FAIL_BIT]) ##1 done_q)
    else $error("Status failure not reported.");
endmodule

/* File: tb/nand_dev_model.sv */
// Behavioural flash device that answers the host's strobed pin cycles.
`timescale 1ns/100ps
module nand_dev_model (
  input  wire logic       clock_i,
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       fail_i,
  input  wire logic       stuck_i,
  output logic [7:0]      dq_o,
  output logic            rb_n_o
);
  logic [7:0] cmd;   // Last command byte taken.
  logic [7:0] ab[4]; // Address bytes of the last address phase.
  int         na;    // Address bytes taken since the last command or program data byte.
  int         col;   // Column pointer for serial read-out.
  int         bsy;   // Busy cycles still to run.
  realtime    t_adr; // Time of the last address strobe rise.
  realtime    gap;   // Address-to-data gap seen on the last program.
  initial begin
    cmd = 8'h00;
    na = 0;
    bsy = 0;
    gap = 1e9;
    dq_o = 8'h5a;
  end
  // Bytes latch on the strobe rise only while selected.
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (cle_i) begin
      cmd = dq_i;
      na = 0;
      if (dq_i inside {8'h30, 8'h10, 8'hd0}) bsy = 20;
      if (dq_i == 8'hff) bsy = 20;
    end else if (ale_i) begin
      ab[na % 4] = dq_i;
      na++;
      t_adr = $realtime;
      col = {ab[1][3:0], ab[0]};
    end else if (cmd == 8'h80 && na > 0) begin
      // Program data never reaches the array, so other pages stay as they were.
      gap = $realtime - t_adr;
      na = 0;
    end
  end
  // Busy counts down after the edge, so the host never races the ready line.
  always @(posedge clock_i) if (bsy > 0 && !stuck_i) bsy <= bsy - 1;
  // A stuck part never comes ready.
  assign rb_n_o = (bsy == 0);
  // Erased cells read all ones; only block 1 page 0 carries a bad mark.
  always @(negedge read_strobe_n_i) if (!ce_n_i) begin
    if (cmd == 8'h70) dq_o = {7'h70, fail_i};
    else if (col == 2048
      && {ab[3], ab[2]} == 16'h0040) dq_o = 8'h00;
    else dq_o = 8'hff;
  end
  // A released bus shows the inverse so stale data is never mistaken for valid.
  // The column pointer survives a deselect, as the page register does.
  always @(posedge read_strobe_n_i) begin
    dq_o = ~dq_o;
    col++;
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the flash host controller.
`timescale 1ns/100ps
module tb_top;
  import nand_host_pkg::*;
  logic clock_i = 0, rst_i = 1, start_i = 0, wr_valid_i = 0, fail = 0, stuck = 0;
  op_e op_i = OP_READ;
  logic [27:0] addr_i = 0;
  logic [11:0] len_i = 0;
  logic [7:0] wr_data_i = 8'h3c, rd_data_o, rd_parity_o, status_o, dq_o;
  logic wr_ready_o, rd_valid_o, busy_o, done_o, fail_o, timeout_o, refused_o;
  logic ce_n_o, cle_o, ale_o, we_n_o, read_strobe_n_o, dq_oe_o;
  wire [7:0] dq_i;
  wire rb_n_i;
  int error_cnt = 0, n_tests = 0, cyc = 0, nwr = 0;
  logic [7:0] rq[$]; // Read bytes in arrival order.
  always #25 clock_i = ~clock_i;
  nand_host #(.RST_BUSY_CYC(50), .PROG_BUSY_CYC(50), .ERASE_BUSY_CYC(50)) dut_u (.*);
  nand_dev_model dev_u (.clock_i, .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o),
    .we_n_i(we_n_o), .read_strobe_n_i(read_strobe_n_o), .dq_i(dq_o), .fail_i(fail),
    .stuck_i(stuck), .dq_o(dq_i), .rb_n_o(rb_n_i));
  always @(posedge clock_i) if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
  // Write bytes handed over: ready stands one cycle per take while valid is held.
  always @(posedge clock_i) if (wr_ready_o === 1'b1 && wr_valid_i) nwr++;
  // A hang counts as a mismatch and still reaches the report.
  always @(posedge clock_i) if (++cyc == 40000) begin
    error_cnt++;
    $display("[ERR] %0t cycle limit reached", $time);
    stop_test();
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One operation, started off the edge, waited for under a bound.
  // Each end also checks that the pins are back to idle with the chip deselected.
  task automatic run(input op_e o, input logic [27:0] a, input logic [11:0] n);
    int k;
    @(negedge clock_i);
    op_i = o;
    addr_i = a;
    len_i = n;
    start_i = 1'b1;
    rq = {};
    nwr = 0;
    @(negedge clock_i) start_i = 0;
    // The done pulse is looked at on falling edges, where it stands settled.
    for (k = 0; k < 3000 && done_o !== 1'b1; k++) @(negedge clock_i);
    if (k >= 3000) chk(8'h00, 8'h01);
    @(negedge clock_i);
    chk({1'b0, busy_o, ce_n_o, cle_o, ale_o, we_n_o, read_strobe_n_o, dq_oe_o},
      8'h26);
  endtask
  task automatic t_read;
    run(OP_READ, {10'd1, 6'd0, 12'd2046}, 4);
    chk(8'(rq.size()), 8'h04);
    foreach (rq[k]) chk(rq[k], (k == 2) ? 8'h00 : 8'hff);
    chk(dev_u.ab[0], 8'hfe);
    chk(dev_u.ab[1], 8'h07);
    chk(dev_u.ab[2], 8'h40);
    chk(dev_u.ab[3], 8'h00);
    chk(rd_parity_o, 8'hff);
    run(OP_READ, {10'd0, 6'd0, 12'd2048}, 1);
    chk(rq[0], 8'hff);
  endtask
  task automatic t_prog_fail;
    fail = 1;
    run(OP_PROG, {10'd3, 6'd4, 12'd0}, 2);
    chk({7'h0, fail_o}, 8'h01);
    chk(status_o, 8'he1);
    chk({7'h0, dev_u.gap >= 100.0}, 8'h01);
    chk(8'(nwr), 8'h02);
    run(OP_STATUS, 28'h0, 0);
    chk({fail_o, status_o[6:0]}, 8'he1);
    fail = 0;
    run(OP_PROG, {10'd3, 6'd5, 12'd0}, 2);
    chk({7'h0, refused_o}, 8'h01);
  endtask
  task automatic t_order;
    run(OP_PROG, {10'd2, 6'd5, 12'd0}, 1);
    chk({6'h0, refused_o, fail_o}, 8'h00);
    run(OP_PROG, {10'd2, 6'd3, 12'd0}, 1);
    chk({7'h0, refused_o}, 8'h01);
    run(OP_PROG, {10'd2, 6'd6, 12'd0}, 1);
    chk({7'h0, refused_o}, 8'h00);
  endtask
  task automatic t_erase;
    run(OP_ERASE, {10'd4, 18'd0}, 0);
    chk(status_o, 8'he0);
    run(OP_ERASE, {10'd3, 18'd0}, 0);
    chk({7'h0, refused_o}, 8'h01);
  endtask
  task automatic t_reset;
    stuck = 1;
    run(OP_RESET, 28'h0, 0);
    chk({7'h0, timeout_o}, 8'h01);
    stuck = 0;
    repeat (30) @(negedge clock_i);
    run(OP_RESET, 28'h0, 0);
    chk({7'h0, timeout_o}, 8'h00);
  endtask
  initial begin
    repeat (8) @(negedge clock_i);
    rst_i = 0;
    wr_valid_i = 1;
    t_read();
    t_prog_fail();
    t_order();
    t_erase();
    t_reset();
    stop_test();
  end
endmodule
